// ---- rtl/dlp_limit.sv ----
// Purpose: Torque limiting, velocity clamp, overspeed, in-motion, foldback, shunt and brake logic
// Assumes: Pin-level inputs are synchronised here; numeric inputs come from same-clock logic
// Notes:   Registers on a plain strobe port, read data one cycle after the read strobe
//
// Operation
// R1: Total torque limit is lowest of five
// R2: Programmable limit counts only when enabled; config bit CFG_TL_ALWAYS also applies it
// R3: Clamp velocity command to 112.5% max speed
// R4: Overspeed fault whenever speed exceeds threshold
// R5: Internal threshold is max(programmed, 150% max)
// R6: Pulse rate implying over 13000 RPM faults
// R7: In-motion output with half-threshold hysteresis
// R8: Threshold capped 100 RPM, checked every 400us
// R9: Position counter counts up on positive command
// R10: Encoder output lines saturate at motor density
// R11: RMS level starts zero, trips at 100%
// R12: RMS foldback limits 80%, releases below 70%
// R13: RMS level models heating, 10 s constant
// R14: Display C for RMS, c for stall
// R15: Repeated phase high current enters stall foldback
// R16: Stall limit 80%, exit 70%/200ms or speed
// R17: Shunt on at 405 V, off below 390 V
// R18: Brake output from release, control, enable
// R19: Brake release overrides every other condition
// R20: Inactive brake means engaged, display b
// R21: Controller commands no motion while braked
// R22: Torque-limit-active when actual below command
// R23: Overspeed fault latched until fault reset
`timescale 1ns/1ps
`default_nettype none
module dlp_limit
   import dlp_pkg::*;
#(
   parameter int MOTION_CYC = MOTION_CYCLES,
   parameter int RMS_TAU    = RMS_TAU_TICKS
)(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   input  wire logic        i_torque_limit_enable,
   input  wire logic        i_brake_release,
   input  wire logic        i_brake_control,
   input  wire logic        i_fault_reset,
   input  wire logic [2:0]  i_phase_high,
   input  wire logic        i_power_stage_en,
   input  wire logic [15:0] i_peak_motor_torque,
   input  wire logic [15:0] i_peak_drive_torque,
   input  wire logic [15:0] i_cont_torque,
   input  wire logic [15:0] i_stall_threshold,
   input  wire logic [15:0] i_motor_max_rpm,
   input  wire logic [15:0] i_motor_enc_lines,
   input  wire logic signed [16:0] i_torque_cmd,
   input  wire logic signed [16:0] i_vel_cmd,
   input  wire logic signed [16:0] i_speed_fb,
   input  wire logic [31:0] i_pulse_rpm_est,
   input  wire logic signed [16:0] i_pos_cmd,
   input  wire logic [15:0] i_bus_volts,
   output logic signed [16:0] o_torque_actual,
   output logic signed [16:0] o_vel_clamped,
   output logic [15:0]      o_torque_limit_total,
   output logic             o_torque_limit_active,
   output logic             o_overspeed_fault,
   output logic             o_in_pos_motion,
   output logic             o_in_neg_motion,
   output logic             o_count_up,
   output logic             o_count_down,
   output logic [15:0]      o_enc_out_lines,
   output logic             o_foldback_active,
   output logic             o_stall_foldback,
   output logic             o_shunt_on,
   output logic             o_brake,
   output logic [7:0]       o_display
);
   typedef struct packed {
      logic [2:0]  tle_s;
      logic [2:0]  tle_m;
      logic [2:0]  brr_s;
      logic [2:0]  brr_m;
      logic [2:0]  brc_s;
      logic [2:0]  brc_m;
      logic [2:0]  frs_s;
      logic [2:0]  frs_m;
      logic [2:0]  ph_s;
      logic [2:0]  ph_m;
      logic        frs_d;
      logic [15:0] tlim_prog;
      logic [15:0] ovs_prog;
      logic [15:0] inm_prog;
      logic [3:0]  cfg;
      logic [15:0] enc_prog;
      logic [15:0] rdata;
      logic [31:0] tick_cnt;
      logic [31:0] rms;
      logic        rms_fold;
      logic [3:0]  stall_hits;
      logic        stall_fold;
      logic [15:0] stall_low_cnt;
      logic        ovs_fault;
      logic        inm_pos;
      logic        inm_neg;
      logic        shunt;
      logic signed [16:0] torque_act;
      logic signed [16:0] vel_cl;
      logic [15:0] tlim_tot;
      logic        tla;
      logic        brake;
      logic        cnt_up;
      logic        cnt_dn;
      logic [15:0] enc_lines;
   } dlp_state_s;

   dlp_state_s st;
   dlp_state_s next_st;

   logic        tick;
   logic        tl_en;
   logic [15:0] lim_min;
   logic [31:0] rms_lim;
   logic [31:0] stall_lim;
   logic [31:0] vmax;
   logic [31:0] ovs_int;
   logic [15:0] inm_thr;
   logic [15:0] speed_abs;
   logic [15:0] tcmd_abs;
   logic [15:0] tq_mag;
   logic [31:0] heat;
   logic [31:0] stall_exit;
   logic [15:0] cont_div;
   logic [63:0] heat_lvl;
   logic [31:0] rms_tgt;

   always_comb
   begin
      next_st = st;
      // R2: limit gate
      tl_en = st.tle_s[0] | st.cfg[CFG_TL_ALWAYS];
      next_st.tle_m = {2'b00, i_torque_limit_enable};
      next_st.tle_s = st.tle_m;
      next_st.brr_m = {2'b00, i_brake_release};
      next_st.brr_s = st.brr_m;
      next_st.brc_m = {2'b00, i_brake_control};
      next_st.brc_s = st.brc_m;
      next_st.frs_m = {2'b00, i_fault_reset};
      next_st.frs_s = st.frs_m;
      next_st.ph_m  = i_phase_high;
      next_st.ph_s  = st.ph_m;
      next_st.frs_d = st.frs_s[0];
      tick = (st.tick_cnt == 32'(MOTION_CYC - 1));
      next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;

      if (i_wr)
      begin
         if (i_addr == REG_TORQUE_LIMIT)
            next_st.tlim_prog = i_wdata;
         else if (i_addr == REG_OVERSPEED)
            next_st.ovs_prog = i_wdata;
         else if (i_addr == REG_INMOTION)
            next_st.inm_prog = i_wdata;
         else if (i_addr == REG_CONFIG)
            next_st.cfg = i_wdata[3:0];
         else if (i_addr == REG_ENC_LINES)
            next_st.enc_prog = i_wdata;
      end
      next_st.rdata = 16'h0;
      if (i_rd)
      begin
         if (i_addr == REG_TORQUE_LIMIT)
            next_st.rdata = st.tlim_prog;
         else if (i_addr == REG_OVERSPEED)
            next_st.rdata = st.ovs_prog;
         else if (i_addr == REG_INMOTION)
            next_st.rdata = st.inm_prog;
         else if (i_addr == REG_CONFIG)
            next_st.rdata = {12'h000, st.cfg};
         else if (i_addr == REG_ENC_LINES)
            next_st.rdata = st.enc_prog;
         else if (i_addr == REG_STATUS)
            next_st.rdata = {7'h00, st.brake, st.shunt, st.stall_fold, st.rms_fold, st.inm_neg,
                             st.inm_pos, st.tla, st.ovs_fault, tl_en};
         else if (i_addr == REG_RMS_LEVEL)
            next_st.rdata = st.rms[31:16];
      end

      // R1: foldback limits
      rms_lim   = 32'(i_cont_torque) * 32'(FOLD_PCT) / 32'd100;
      stall_lim = 32'(i_stall_threshold) * 32'(FOLD_PCT) / 32'd100;
      // R1: lowest limit
      lim_min = (i_peak_motor_torque < i_peak_drive_torque) ? i_peak_motor_torque : i_peak_drive_torque;
      // R12: RMS clamp
      if (st.rms_fold && rms_lim[15:0] < lim_min)
         lim_min = rms_lim[15:0];
      // R16: stall clamp
      if (st.stall_fold && stall_lim[15:0] < lim_min)
         lim_min = stall_lim[15:0];
      // R2: programmable term
      if (tl_en && st.tlim_prog < lim_min)
         lim_min = st.tlim_prog;
      next_st.tlim_tot = lim_min;
      tcmd_abs = i_torque_cmd[16] ? 16'(-i_torque_cmd) : i_torque_cmd[15:0];
      if (tcmd_abs > lim_min)
         next_st.torque_act = i_torque_cmd[16] ? -$signed({1'b0, lim_min}) : $signed({1'b0, lim_min});
      else
         next_st.torque_act = i_torque_cmd;
      // R22: limit active flag
      next_st.tla = (tcmd_abs > lim_min);

      // R3: velocity clamp
      vmax = 32'(i_motor_max_rpm) * 32'(VCLAMP_NUM) / 32'(VCLAMP_DEN);
      if (i_vel_cmd > $signed(vmax[16:0]))
         next_st.vel_cl = $signed(vmax[16:0]);
      else if (i_vel_cmd < -$signed(vmax[16:0]))
         next_st.vel_cl = -$signed(vmax[16:0]);
      else
         next_st.vel_cl = i_vel_cmd;

      speed_abs = i_speed_fb[16] ? 16'(-i_speed_fb) : i_speed_fb[15:0];
      // R5: internal threshold
      ovs_int = 32'(i_motor_max_rpm) * 32'(OVS_NUM) / 32'(OVS_DEN);
      if (32'(st.ovs_prog) > ovs_int)
         ovs_int = 32'(st.ovs_prog);
      // R23: latched until reset edge
      if (st.frs_s[0] && !st.frs_d)
         next_st.ovs_fault = 1'b0;
      // R4: overspeed compare
      if (32'(speed_abs) > ovs_int)
         next_st.ovs_fault = 1'b1;
      // R6: pulse rate ceiling
      if (st.cfg[CFG_PULSE_MODE] && i_pulse_rpm_est > 32'(PULSE_CEIL_RPM))
         next_st.ovs_fault = 1'b1;

      // R8: threshold cap
      inm_thr = (st.inm_prog > INMOTION_MAX) ? INMOTION_MAX : st.inm_prog;
      // R8: periodic evaluation
      if (tick)
      begin
         // R7: hysteresis
         if (speed_abs > inm_thr)
         begin
            next_st.inm_pos = !i_speed_fb[16];
            next_st.inm_neg = i_speed_fb[16];
         end
         else if (speed_abs < (inm_thr >> 1))
         begin
            next_st.inm_pos = 1'b0;
            next_st.inm_neg = 1'b0;
         end
      end

      // R13: thermal model
      tq_mag = (o_torque_actual[16] ? 16'(-o_torque_actual) : o_torque_actual[15:0]);
      heat = 32'(tq_mag) + 32'(speed_abs >> 4);
      cont_div = (i_cont_torque == 16'h0000) ? 16'h0001 : i_cont_torque;
      heat_lvl = 64'(heat) * 64'(RMS_FULL) / 64'(cont_div);
      // Headroom clamp keeps the sum from wrapping
      rms_tgt = (heat_lvl > 64'h0000_0000_0FFF_FFFF) ? 32'h0FFF_FFFF : heat_lvl[31:0];
      if (tick)
         next_st.rms = st.rms + rms_tgt / 32'(RMS_TAU) - st.rms / 32'(RMS_TAU);
      // R11: trip at full
      if (st.rms >= RMS_FULL)
         next_st.rms_fold = 1'b1;
      // R12: release below 70
      else if (st.rms < RMS_FULL / 32'd100 * 32'(EXIT_PCT))
         next_st.rms_fold = 1'b0;

      // R15: repeated phase highs
      if (tick)
      begin
         if (|st.ph_s)
            next_st.stall_hits = (st.stall_hits == 4'hF) ? 4'hF : st.stall_hits + 4'h1;
         else
            next_st.stall_hits = 4'h0;
      end
      if (st.stall_hits >= 4'h8)
         next_st.stall_fold = 1'b1;
      // R16: stall exit
      stall_exit = 32'(i_stall_threshold) * 32'(EXIT_PCT) / 32'd100;
      if (st.stall_fold && tick)
      begin
         if (32'(tq_mag) < stall_exit)
            next_st.stall_low_cnt = st.stall_low_cnt + 16'h1;
         else
            next_st.stall_low_cnt = 16'h0;
         if (st.stall_low_cnt >= 16'(STALL_HOLD_TICKS) || speed_abs > STALL_EXIT_RPM)
         begin
            next_st.stall_fold = 1'b0;
            next_st.stall_hits = 4'h0;
            next_st.stall_low_cnt = 16'h0;
         end
      end

      // R17: shunt hysteresis
      if (i_bus_volts >= SHUNT_ON_V)
         next_st.shunt = 1'b1;
      else if (i_bus_volts < SHUNT_OFF_V)
         next_st.shunt = 1'b0;

      // R9: count direction
      next_st.cnt_up = (i_pos_cmd > 17'sh00000);
      next_st.cnt_dn = (i_pos_cmd < 17'sh00000);
      // R10: encoder output saturation
      if (!st.cfg[CFG_ENC_SCALE])
         next_st.enc_lines = i_motor_enc_lines;
      else if (st.enc_prog > i_motor_enc_lines)
         next_st.enc_lines = i_motor_enc_lines;
      else
         next_st.enc_lines = st.enc_prog;

      // R19: release overrides
      if (st.brr_s[0])
         next_st.brake = 1'b1;
      // R18: brake table
      else
         next_st.brake = i_power_stage_en & ~st.brc_s[0];
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         st <= '0;
         st.tlim_prog <= TORQUE_LIMIT_RST;
         st.ovs_prog  <= OVERSPEED_DEF;
         st.inm_prog  <= INMOTION_DEF;
      end
      else
         st <= next_st;
   end

   assign o_rdata              = st.rdata;
   assign o_torque_actual      = st.torque_act;
   assign o_vel_clamped        = st.vel_cl;
   assign o_torque_limit_total = st.tlim_tot;
   assign o_torque_limit_active = st.tla;
   assign o_overspeed_fault    = st.ovs_fault;
   assign o_in_pos_motion      = st.inm_pos;
   assign o_in_neg_motion      = st.inm_neg;
   assign o_count_up           = st.cnt_up;
   assign o_count_down         = st.cnt_dn;
   assign o_enc_out_lines      = st.enc_lines;
   assign o_foldback_active    = st.rms_fold;
   assign o_stall_foldback     = st.stall_fold;
   assign o_shunt_on           = st.shunt;
   assign o_brake              = st.brake;
   // R14: display codes
   // R20: brake engaged shows b
   assign o_display            = st.rms_fold ? DISP_RMS : st.stall_fold ? DISP_STALL :
                                 !st.brake ? DISP_BRAKE : DISP_NONE;
endmodule : dlp_limit
`default_nettype wire

// ---- rtl/dlp_pkg.sv ----
// Purpose: Constants for the drive limit and protection block
// Assumes: Speeds in RPM, torques in per-mille of continuous motor torque
// Notes:   Bus voltage in volts
package dlp_pkg;
   localparam int          CLK_HZ            = 40_000_000;
   localparam int          MOTION_PERIOD_US  = 400;
   localparam int          MOTION_CYCLES     = CLK_HZ / 1_000_000 * MOTION_PERIOD_US;
   localparam int          STALL_HOLD_MS     = 200;
   localparam int          STALL_HOLD_TICKS  = STALL_HOLD_MS * 1000 / MOTION_PERIOD_US;
   localparam int          RMS_TAU_S         = 10;
   localparam int          RMS_TAU_TICKS     = RMS_TAU_S * 1_000_000 / MOTION_PERIOD_US;
   localparam int          RMS_SHIFT         = 15;
   localparam logic [15:0] OVERSPEED_DEF     = 16'h32C8;
   localparam logic [15:0] PULSE_CEIL_RPM    = 16'h32C8;
   localparam logic [15:0] INMOTION_DEF      = 16'h000A;
   localparam logic [15:0] INMOTION_MAX      = 16'h0064;
   localparam logic [15:0] STALL_EXIT_RPM    = 16'h0064;
   localparam logic [15:0] SHUNT_ON_V        = 16'h0195;
   localparam logic [15:0] SHUNT_OFF_V       = 16'h0186;
   localparam int          FOLD_PCT          = 80;
   localparam int          EXIT_PCT          = 70;
   localparam int          VCLAMP_NUM        = 9;
   localparam int          VCLAMP_DEN        = 8;
   localparam int          OVS_NUM           = 3;
   localparam int          OVS_DEN           = 2;
   localparam logic [31:0] RMS_FULL          = 32'h0010_0000;
   localparam logic [7:0]  DISP_RMS          = 8'h43;
   localparam logic [7:0]  DISP_STALL        = 8'h63;
   localparam logic [7:0]  DISP_BRAKE        = 8'h62;
   localparam logic [7:0]  DISP_NONE         = 8'h20;
   localparam logic [3:0]  REG_TORQUE_LIMIT  = 4'h0;
   localparam logic [3:0]  REG_OVERSPEED     = 4'h1;
   localparam logic [3:0]  REG_INMOTION      = 4'h2;
   localparam logic [3:0]  REG_CONFIG        = 4'h3;
   localparam logic [3:0]  REG_ENC_LINES     = 4'h4;
   localparam logic [3:0]  REG_STATUS        = 4'h5;
   localparam logic [3:0]  REG_RMS_LEVEL     = 4'h6;
   localparam int          CFG_DIR_CCW       = 0;
   localparam int          CFG_ENC_SCALE     = 1;
   localparam int          CFG_TL_ALWAYS     = 2;
   localparam int          CFG_PULSE_MODE    = 3;
   localparam logic [15:0] TORQUE_LIMIT_RST  = 16'hFFFF;
endpackage : dlp_pkg

// ---- test/dlp_chk.sv ----
// Purpose: Port assertions for the limit block
// Assumes: One clock, async low reset
// Notes:   Tracks overspeed threshold writes
`timescale 1ns/1ps
`default_nettype none
module dlp_chk
   import dlp_pkg::*;
(
   input wire logic               i_clk,
   input wire logic               i_resetn,
   input wire logic [3:0]         i_addr,
   input wire logic [15:0]        i_wdata,
   input wire logic               i_wr,
   input wire logic               i_brake_release,
   input wire logic               i_brake_control,
   input wire logic               i_fault_reset,
   input wire logic [15:0]        i_peak_motor_torque,
   input wire logic [15:0]        i_motor_max_rpm,
   input wire logic signed [16:0] i_speed_fb,
   input wire logic [15:0]        i_bus_volts,
   input wire logic [15:0]        o_torque_limit_total,
   input wire logic               o_overspeed_fault,
   input wire logic               o_foldback_active,
   input wire logic               o_stall_foldback,
   input wire logic               o_shunt_on,
   input wire logic               o_brake,
   input wire logic [7:0]         o_display
);
   logic [15:0] ovs_q;
   int          lim;
   int          thr;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   assign lim = int'(i_motor_max_rpm) * OVS_NUM / OVS_DEN;
   assign thr = (int'(ovs_q) > lim) ? int'(ovs_q) : lim;
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         ovs_q <= OVERSPEED_DEF;
      else if (i_wr && i_addr == REG_OVERSPEED)
         ovs_q <= i_wdata;
   end
   tl_min_a: assert property (1'b1 |=> o_torque_limit_total <= $past(i_peak_motor_torque))
      else $error("total limit above peak");
   ovs_set_a: assert property (i_speed_fb > thr |=> o_overspeed_fault)
      else $error("overspeed not flagged");
   ovs_hold_a: assert property (!i_fault_reset [*6] ##0 o_overspeed_fault |=> o_overspeed_fault)
      else $error("overspeed cleared alone");
   shunt_on_a: assert property (i_bus_volts >= SHUNT_ON_V |=> o_shunt_on)
      else $error("shunt not on");
   shunt_off_a: assert property (i_bus_volts < SHUNT_OFF_V |=> !o_shunt_on)
      else $error("shunt not off");
   brake_rel_a: assert property (i_brake_release [*4] |=> o_brake)
      else $error("release ignored");
   brake_eng_a: assert property ((i_brake_control && !i_brake_release) [*4] |=> !o_brake)
      else $error("brake not engaged");
   disp_b_a: assert property (!o_brake && !o_foldback_active && !o_stall_foldback |-> o_display == DISP_BRAKE)
      else $error("brake display wrong");
endmodule : dlp_chk
bind dlp_limit dlp_chk dlp_chk_inst (.*);
`default_nettype wire

// ---- test/dlp_ctrl_model.sv ----
// Purpose: Controller driving the pin functions
// Assumes: Bench gives request levels
// Notes:   Bits: 0 limit en, 1 release, 2 brake ctl, 3 reset
`timescale 1ns/1ps
`default_nettype none
module dlp_ctrl_model (
   input  wire logic               i_clk,
   input  wire logic               i_brake,
   input  wire logic [3:0]         i_req,
   input  wire logic signed [16:0] i_vel_target,
   output logic [3:0]              o_pins,
   output logic signed [16:0]      o_vel
);
   always @(posedge i_clk)
   begin
      o_pins <= i_req;
      o_vel <= i_brake ? i_vel_target : 17'sh00000;
   end
endmodule : dlp_ctrl_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the limit block
// Assumes: Motion tick shortened to 8 cycles
// Notes:   Pins come from the controller model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dlp_pkg::*;
   logic i_clk, i_resetn, i_wr, i_rd, i_power_stage_en, o_torque_limit_active, o_overspeed_fault;
   logic i_torque_limit_enable, i_brake_release, i_brake_control, i_fault_reset, o_in_pos_motion;
   logic o_in_neg_motion, o_count_up, o_count_down, o_foldback_active, o_stall_foldback, o_shunt_on, o_brake;
   logic [2:0] i_phase_high;
   logic [3:0] i_addr, req, pins;
   logic [7:0] o_display;
   logic [15:0] i_wdata, o_rdata, i_peak_motor_torque, i_peak_drive_torque, i_cont_torque, i_bus_volts;
   logic [15:0] i_stall_threshold, i_motor_max_rpm, i_motor_enc_lines, o_torque_limit_total, o_enc_out_lines;
   logic [31:0] i_pulse_rpm_est;
   logic signed [16:0] i_torque_cmd, i_vel_cmd, i_speed_fb, i_pos_cmd, o_torque_actual, o_vel_clamped, vt;
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   assign {i_fault_reset, i_brake_control, i_brake_release, i_torque_limit_enable} = pins;
   dlp_limit #(.MOTION_CYC(8), .RMS_TAU(4)) dlp_limit_inst (.*);
   dlp_ctrl_model dlp_ctrl_model_inst (.i_clk(i_clk), .i_brake(o_brake), .i_req(req),
      .i_vel_target(vt), .o_pins(pins), .o_vel(i_vel_cmd));
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask : wt
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk) i_wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk) i_rd <= 1'b0;
      @(negedge i_clk);
      chk(o_rdata, exp);
   endtask : rdc
   task automatic frst(input logic signed [16:0] sp);
      @(posedge i_clk) i_speed_fb <= sp;
      wt(6);
      chk(o_overspeed_fault, 1'b1);
      @(posedge i_clk) req[3] <= 1'b1;
      wt(6);
      @(posedge i_clk) req[3] <= 1'b0;
      wt(6);
   endtask : frst
   task automatic t_regs;
      rdc(REG_OVERSPEED, OVERSPEED_DEF);
      rdc(REG_INMOTION, INMOTION_DEF);
      rdc(REG_RMS_LEVEL, 16'h0000);
      wr(4'hF, 16'h1234);
      rdc(4'hF, 16'h0000);
      $display("test registers done");
   endtask : t_regs
   task automatic t_lim;
      @(posedge i_clk) i_torque_cmd <= 17'sh00200;
      wr(REG_TORQUE_LIMIT, 16'h0100);
      wt(6);
      chk(o_torque_limit_total, 16'h0300);
      chk(o_torque_limit_active, 1'b0);
      @(posedge i_clk) req[0] <= 1'b1;
      wt(8);
      chk(o_torque_actual, 17'sh00100);
      chk(o_torque_limit_active, 1'b1);
      @(posedge i_clk);
      req <= 4'h2;
      vt <= 17'sh02000;
      wt(10);
      chk(o_vel_clamped, 17'sh01194);
      @(posedge i_clk) req <= 4'h0;
      wt(10);
      chk(o_vel_clamped, 17'sh00000);
      $display("test limits done");
   endtask : t_lim
   task automatic t_ovs;
      @(posedge i_clk) i_speed_fb <= 17'sh032C9;
      wt(3);
      chk(o_overspeed_fault, 1'b1);
      frst(17'sh0176F);
      wr(REG_OVERSPEED, 16'h0100);
      wt(3);
      chk(o_overspeed_fault, 1'b0);
      @(posedge i_clk) i_speed_fb <= 17'sh01771;
      wt(3);
      chk(o_overspeed_fault, 1'b1);
      frst(17'sh00000);
      wr(REG_CONFIG, 16'h0008);
      @(posedge i_clk) i_pulse_rpm_est <= 32'h0000_32C9;
      wt(3);
      chk(o_overspeed_fault, 1'b1);
      @(posedge i_clk) i_pulse_rpm_est <= 32'h0000_0000;
      frst(17'sh00000);
      chk(o_overspeed_fault, 1'b0);
      $display("test overspeed done");
   endtask : t_ovs
   task automatic t_mot;
      logic signed [16:0] sp [6] = '{17'sh0000B, 17'sh00006, 17'sh00004, -17'sh0000B, 17'sh00000, 17'sh00096};
      logic [1:0] ex [6] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h2};
      for (int k = 0; k < 6; k++)
      begin
         if (k == 5)
            wr(REG_INMOTION, 16'h00C8);
         @(posedge i_clk) i_speed_fb <= sp[k];
         wt(24);
         chk({o_in_pos_motion, o_in_neg_motion}, ex[k]);
      end
      @(posedge i_clk) i_speed_fb <= 17'sh00000;
      $display("test motion done");
   endtask : t_mot
   task automatic t_out;
      logic [15:0] v [5] = '{16'h0194, 16'h0195, 16'h0186, 16'h0185, 16'h0186};
      logic [4:0] s = 5'b01100;
      for (int k = 0; k < 8; k++)
      begin
         @(posedge i_clk);
         req <= {1'b0, k[1], k[2], 1'b0};
         i_power_stage_en <= k[0];
         i_bus_volts <= v[k % 5];
         wt(8);
         chk(o_brake, k[2] | (k[0] & ~k[1]));
         chk(o_display, (k[2] | (k[0] & ~k[1])) ? DISP_NONE : DISP_BRAKE);
         chk(o_shunt_on, s[4 - k % 5]);
      end
      wr(REG_CONFIG, 16'h0002);
      wr(REG_ENC_LINES, 16'h0800);
      wt(2);
      chk(o_enc_out_lines, 16'h0400);
      wr(REG_ENC_LINES, 16'h0200);
      wt(2);
      chk(o_enc_out_lines, 16'h0200);
      @(posedge i_clk) i_pos_cmd <= 17'sh00005;
      wt(2);
      chk({o_count_up, o_count_down}, 2'h2);
      @(posedge i_clk) i_pos_cmd <= -17'sh00005;
      wt(2);
      chk({o_count_up, o_count_down}, 2'h1);
      $display("test outputs done");
   endtask : t_out
   task automatic t_stl;
      @(posedge i_clk);
      i_power_stage_en <= 1'b0;
      i_phase_high <= 3'h2;
      i_stall_threshold <= 16'h0200;
      for (int k = 0; k < 300 && o_stall_foldback !== 1'b1; k++)
         @(posedge i_clk);
      wt(1);
      chk(o_stall_foldback, 1'b1);
      chk(o_display, DISP_STALL);
      chk(o_torque_limit_total, 16'h0199);
      @(posedge i_clk);
      i_phase_high <= 3'h0;
      i_speed_fb <= 17'sh000C8;
      wt(8);
      chk(o_stall_foldback, 1'b0);
      $display("test stall done");
   endtask : t_stl
   task automatic t_rms;
      @(posedge i_clk);
      i_peak_motor_torque <= 16'h0400;
      i_torque_cmd <= 17'sh00300;
      i_speed_fb <= 17'sh01000;
      for (int k = 0; k < 300 && o_foldback_active !== 1'b1; k++)
         wt(1);
      wt(1);
      chk(o_foldback_active, 1'b1);
      chk(o_torque_limit_total, 16'h0320);
      chk(o_display, DISP_RMS);
      @(posedge i_clk);
      i_torque_cmd <= 17'sh00000;
      i_speed_fb <= 17'sh00000;
      wt(8);
      chk(o_foldback_active, 1'b1);
      for (int k = 0; k < 300 && o_foldback_active !== 1'b0; k++)
         wt(1);
      chk(o_foldback_active, 1'b0);
      $display("test rms done");
   endtask : t_rms
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   initial
   begin
      i_resetn = 1'b0;
      {i_wr, i_rd, i_power_stage_en, i_addr, i_wdata, req, vt, i_phase_high, i_bus_volts} = '0;
      {i_pulse_rpm_est, i_torque_cmd, i_speed_fb, i_pos_cmd} = '0;
      i_peak_motor_torque = 16'h0300;
      i_peak_drive_torque = 16'h0400;
      i_cont_torque = 16'h03E8;
      i_stall_threshold = 16'h0500;
      i_motor_max_rpm = 16'h0FA0;
      i_motor_enc_lines = 16'h0400;
      repeat (5) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_regs();
      t_lim();
      t_ovs();
      t_mot();
      t_out();
      t_stl();
      t_rms();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
